// [core/pinu_top.sv]
// pinu_top: pin integration unit with AXI4-Lite registers
`timescale 1ns/1ns
module pinu_top
#(
	parameter int NPORT = pinu_pkg::NPORT_MAX,
	parameter int PW    = pinu_pkg::PWIDTH,
	parameter logic [NPORT*PW-1:0] EXT_PIN_MASK = {{(NPORT*PW-32){1'b0}}, 32'hffff_ffff}
)
(
	// clock and reset
	input  wire logic                      clk,
	input  wire logic                      rst_n,
	// axi4-lite slave
	input  wire logic [11:0]               s_axi_awaddr,
	input  wire logic                      s_axi_awvalid,
	output logic                           s_axi_awready,
	input  wire logic [31:0]               s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	input  wire logic                      s_axi_wvalid,
	output logic                           s_axi_wready,
	output logic [1:0]                     s_axi_bresp,
	output logic                           s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	input  wire logic [11:0]               s_axi_araddr,
	input  wire logic                      s_axi_arvalid,
	output logic                           s_axi_arready,
	output logic [31:0]                    s_axi_rdata,
	output logic [1:0]                     s_axi_rresp,
	output logic                           s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	// package pins
	input  wire logic [NPORT-1:0][PW-1:0]  pin_in,
	output logic [NPORT-1:0][PW-1:0]       pin_out,
	output logic [NPORT-1:0][PW-1:0]       pin_oe,
	// alternate peripheral functions
	input  wire logic [NPORT-1:0][PW-1:0]  periph_out,
	input  wire logic [NPORT-1:0][PW-1:0]  periph_oe,
	output logic [NPORT-1:0][PW-1:0]       periph_in,
	// external bus interface unit
	input  wire logic [NPORT-1:0][PW-1:0]  ext_out,
	input  wire logic [NPORT-1:0][PW-1:0]  ext_oe,
	output logic [NPORT-1:0][PW-1:0]       ext_own,
	output logic                           boot_ext,
	// mode straps and status
	input  wire logic [1:0]                mode_strap,
	input  wire logic                      flash_secure,
	output pinu_pkg::pinu_mode_t           chip_mode,
	output logic                           irq
);
	import pinu_pkg::*;

	typedef logic [NPORT-1:0][PW-1:0] pinu_pins_t;

	// whole-port register files
	pinu_pins_t data_reg, dir_reg, psel_reg, imask_reg, fen_reg, istat_reg;
	pinu_pins_t sync1_reg, sync2_reg, pin_out_reg, pin_oe_reg, own_reg;
	pinu_pins_t rise_arr, level_arr;
	logic       swap_reg;
	logic       irq_reg;
	logic       boot_ext_reg;
	pinu_mode_t mode_reg;
	pinu_cap_t  cap_state;
	logic [2:0] strap_s1_reg, strap_s2_reg;

	// bus side state
	logic        awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
	logic [11:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0]  wstrb_reg;
	logic [1:0]  bresp_reg, rresp_reg;
	logic [31:0] rdata_reg;
	logic        do_write, rd_take;
	logic [3:0]  wr_slot, rd_slot;
	logic [7:0]  wr_ofs, rd_ofs;
	logic [31:0] rd_next;
	logic        rd_ok;
	pinu_pins_t  rd_clr, wr_pin_mask;

	pinu_filt_if #(.N(NPORT*PW)) filt();

	// slot remap: the swap bit lets code for either variant find its port
	function automatic logic [3:0] slot_map(input logic [3:0] s, input logic sw);
		if (sw && s == SLOT_PRI)
			return SLOT_ALT;
		else if (sw && s == SLOT_ALT)
			return SLOT_PRI;
		return s;
	endfunction

	function automatic logic is_pin(input logic [7:0] o);
		return o[7:6] == OFS_PIN_BASE[7:6] && o[1:0] == 2'b00;
	endfunction

	function automatic logic ofs_ok(input logic [3:0] s, input logic [7:0] o);
		if (s == SLOT_GLB)
			return o == OFS_GCTRL || o == OFS_GSTAT;
		if (s >= 4'(NPORT))
			return 1'b0;
		return is_pin(o) || o == OFS_DATA || o == OFS_DIR || o == OFS_PSEL || o == OFS_IMASK
			|| o == OFS_FEN || o == OFS_LEVEL || o == OFS_ISTAT || o == OFS_MIRROR;
	endfunction

	function automatic logic [PW-1:0] merge(input logic [PW-1:0] old, input logic [31:0] d,
		input logic [3:0] st);
		logic [PW-1:0] r;
		r = old;
		for (int b = 0; b < PW; b++)
			if (st[b/8])
				r[b] = d[b];
		return r;
	endfunction

	function automatic logic expanded(input pinu_mode_t m);
		return m == MODE_NEXP || m == MODE_SEXP;
	endfunction

	function automatic pinu_mode_t decode_mode(input logic [1:0] st, input logic sec);
		unique case (st)
			STRAP_EXP:    return sec ? MODE_SEXP : MODE_NEXP;
			STRAP_DFLASH: return sec ? MODE_SDFB : MODE_DFB;
			default:      return sec ? MODE_SSC : MODE_NSC;
		endcase
	endfunction

	// pin and strap synchronisers; nothing reads the first stage but the second
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sync1_reg    <= '0;
			sync2_reg    <= '0;
			strap_s1_reg <= 3'h0;
			strap_s2_reg <= 3'h0;
		end
		else
		begin
			sync1_reg    <= pin_in;
			sync2_reg    <= sync1_reg;
			strap_s1_reg <= {flash_secure, mode_strap};
			strap_s2_reg <= strap_s1_reg;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cap_state    <= CAP_SYNC0;
			mode_reg     <= MODE_NSC;
			own_reg      <= '0;
			boot_ext_reg <= 1'b0;
		end
		else
		begin
			unique case (cap_state)
				CAP_SYNC0: cap_state <= CAP_SYNC1;
				CAP_SYNC1: cap_state <= CAP_TAKE;
				CAP_TAKE:
				begin
					cap_state    <= CAP_RUN;
					mode_reg     <= decode_mode(strap_s2_reg[1:0], strap_s2_reg[2]);
					// bus pins claimed in expanded modes
					own_reg      <= expanded(decode_mode(strap_s2_reg[1:0], strap_s2_reg[2]))
						? pinu_pins_t'(EXT_PIN_MASK) : '0;
					boot_ext_reg <= expanded(decode_mode(strap_s2_reg[1:0], strap_s2_reg[2]));
				end
				CAP_RUN: cap_state <= CAP_RUN;
			endcase
		end
	end

	// write address and data are taken independently, in either order
	assign do_write = !awready_reg && !wready_reg && !bvalid_reg;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			awready_reg <= 1'b1;
			wready_reg  <= 1'b1;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= RESP_OKAY;
			awaddr_reg  <= 12'h000;
			wdata_reg   <= 32'h0000_0000;
			wstrb_reg   <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && awready_reg)
			begin
				awaddr_reg  <= s_axi_awaddr;
				awready_reg <= 1'b0;
			end
			if (s_axi_wvalid && wready_reg)
			begin
				wdata_reg  <= s_axi_wdata;
				wstrb_reg  <= s_axi_wstrb;
				wready_reg <= 1'b0;
			end
			if (do_write)
			begin
				bvalid_reg <= 1'b1;
				bresp_reg  <= ofs_ok(wr_slot, wr_ofs) ? RESP_OKAY : RESP_SLVERR;
			end
			else if (bvalid_reg && s_axi_bready)
			begin
				bvalid_reg  <= 1'b0;
				awready_reg <= 1'b1;
				wready_reg  <= 1'b1;
			end
		end
	end

	// both bus sides decode through the slot remap
	assign wr_slot = slot_map(awaddr_reg[11:8], swap_reg);
	assign wr_ofs  = awaddr_reg[7:0];
	assign rd_slot = slot_map(s_axi_araddr[11:8], swap_reg);
	assign rd_ofs  = s_axi_araddr[7:0];
	assign rd_take = s_axi_arvalid && arready_reg;

	// one-hot of the pin a per-pin write aims at
	always_comb
	begin
		wr_pin_mask = '0;
		for (int p = 0; p < NPORT; p++)
			if (do_write && wr_slot == 4'(p) && is_pin(wr_ofs) && wstrb_reg[0])
				wr_pin_mask[p][wr_ofs[5:2]] = 1'b1;
	end

	// port-wide data writes, per-pin writes, mirror writes
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			data_reg <= {NPORT{RST_DATA}};
			dir_reg  <= {NPORT{RST_DIR}};
			psel_reg <= {NPORT{RST_PSEL}};
		end
		else if (do_write)
		begin
			for (int p = 0; p < NPORT; p++)
				if (wr_slot == 4'(p))
				begin
					if (wr_ofs == OFS_DATA || wr_ofs == OFS_MIRROR)
						data_reg[p] <= merge(data_reg[p], wdata_reg, wstrb_reg);
					if (wr_ofs == OFS_DIR)
						dir_reg[p] <= merge(dir_reg[p], wdata_reg, wstrb_reg);
					if (wr_ofs == OFS_PSEL)
						psel_reg[p] <= merge(psel_reg[p], wdata_reg, wstrb_reg);
					if (is_pin(wr_ofs) && wstrb_reg[0])
					begin
						data_reg[p][wr_ofs[5:2]] <= wdata_reg[PINB_DATA];
						dir_reg[p][wr_ofs[5:2]]  <= wdata_reg[PINB_DIR];
						psel_reg[p][wr_ofs[5:2]] <= wdata_reg[PINB_PSEL];
					end
				end
		end
	end

	// interrupt mask, filter enable and swap control
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			imask_reg <= '0;
			fen_reg   <= '0;
			swap_reg  <= 1'b0;
		end
		else if (do_write)
		begin
			for (int p = 0; p < NPORT; p++)
				if (wr_slot == 4'(p) && wr_ofs == OFS_IMASK)
					imask_reg[p] <= merge(imask_reg[p], wdata_reg, wstrb_reg);
				else if (wr_slot == 4'(p) && wr_ofs == OFS_FEN)
					fen_reg[p] <= merge(fen_reg[p], wdata_reg, wstrb_reg);
			if (wr_slot == SLOT_GLB && wr_ofs == OFS_GCTRL && wstrb_reg[0])
				swap_reg <= wdata_reg[GCTRL_SWAP];
		end
	end

	// filtered levels feed the edge detector
	assign filt.raw    = sync2_reg;
	assign filt.enable = fen_reg;
	assign rise_arr    = filt.rise;
	assign level_arr   = filt.level;

	pinu_filter #(.N(NPORT*PW), .CYC(FILT_CYCLES)) u_filter
	(
		.clk   (clk),
		.rst_n (rst_n),
		.f     (filt.flt)
	);

	// clear-on-read mask for the status register being read
	always_comb
	begin
		rd_clr = '0;
		for (int p = 0; p < NPORT; p++)
			if (rd_take && rd_slot == 4'(p) && rd_ofs == OFS_ISTAT)
				rd_clr[p] = '1;
	end

	// sticky flags; a new event beats the read-clear
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			istat_reg <= '0;
			irq_reg   <= 1'b0;
		end
		else
		begin
			istat_reg <= (istat_reg & ~rd_clr) | rise_arr;
			irq_reg   <= |(((istat_reg & ~rd_clr) | rise_arr) & imask_reg);
		end
	end

	// read decode, answered one cycle after the address is taken
	always_comb
	begin
		rd_next = 32'h0000_0000;
		rd_ok   = ofs_ok(rd_slot, rd_ofs);
		for (int p = 0; p < NPORT; p++)
			if (rd_slot == 4'(p))
			begin
				unique case (1'b1)
					rd_ofs == OFS_DATA:   rd_next[PW-1:0] = data_reg[p];
					rd_ofs == OFS_DIR:    rd_next[PW-1:0] = dir_reg[p];
					rd_ofs == OFS_PSEL:   rd_next[PW-1:0] = psel_reg[p];
					rd_ofs == OFS_IMASK:  rd_next[PW-1:0] = imask_reg[p];
					rd_ofs == OFS_FEN:    rd_next[PW-1:0] = fen_reg[p];
					rd_ofs == OFS_LEVEL:  rd_next[PW-1:0] = sync2_reg[p];
					rd_ofs == OFS_ISTAT:  rd_next[PW-1:0] = istat_reg[p];
					// whole port in one read, level high and data low
					rd_ofs == OFS_MIRROR: rd_next = {sync2_reg[p], data_reg[p]};
					is_pin(rd_ofs):
					begin
						rd_next[PINB_DATA]  = data_reg[p][rd_ofs[5:2]];
						rd_next[PINB_DIR]   = dir_reg[p][rd_ofs[5:2]];
						rd_next[PINB_PSEL]  = psel_reg[p][rd_ofs[5:2]];
						rd_next[PINB_LEVEL] = sync2_reg[p][rd_ofs[5:2]];
					end
					default: rd_next = 32'h0000_0000;
				endcase
			end
		if (rd_slot == SLOT_GLB && rd_ofs == OFS_GCTRL)
			rd_next[GCTRL_SWAP] = swap_reg;
		if (rd_slot == SLOT_GLB && rd_ofs == OFS_GSTAT)
			rd_next[3:0] = {boot_ext_reg, mode_reg};
	end

	// read channel
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			arready_reg <= 1'b1;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= 32'h0000_0000;
			rresp_reg   <= RESP_OKAY;
		end
		else if (rd_take)
		begin
			arready_reg <= 1'b0;
			rvalid_reg  <= 1'b1;
			rdata_reg   <= rd_next;
			rresp_reg   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end
		else if (rvalid_reg && s_axi_rready)
		begin
			arready_reg <= 1'b1;
			rvalid_reg  <= 1'b0;
		end
	end

	// pin drive mux; nothing driven until the mode is known
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_out_reg <= '0;
			pin_oe_reg  <= '0;
		end
		else if (cap_state != CAP_RUN)
		begin
			pin_out_reg <= '0;
			pin_oe_reg  <= '0;
		end
		else
		begin
			pin_out_reg <= (own_reg & ext_out) | (~own_reg & psel_reg & periph_out)
				| (~own_reg & ~psel_reg & data_reg);
			pin_oe_reg  <= (own_reg & ext_oe) | (~own_reg & psel_reg & periph_oe)
				| (~own_reg & ~psel_reg & dir_reg);
		end
	end

	// outputs, all from flops
	assign s_axi_awready = awready_reg;
	assign s_axi_wready  = wready_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;
	assign pin_out       = pin_out_reg;
	assign pin_oe        = pin_oe_reg;
	assign periph_in     = sync2_reg;
	assign ext_own       = own_reg;
	assign boot_ext      = boot_ext_reg;
	assign chip_mode     = mode_reg;
	assign irq           = irq_reg;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_istat_read;
		rd_take && rd_ofs == OFS_ISTAT && rd_slot < 4'(NPORT);
	endsequence

	sequence s_take_mode;
		cap_state == CAP_TAKE ##1 cap_state == CAP_RUN;
	endsequence

	a_mode_decided: assert property (cap_state == CAP_TAKE |=>
		mode_reg == $past(decode_mode(strap_s2_reg[1:0], strap_s2_reg[2])))
		else $error("chip mode not taken from straps");
	a_exp_owns_pins: assert property (s_take_mode |->
		own_reg == (expanded(mode_reg) ? pinu_pins_t'(EXT_PIN_MASK) : '0)
		&& boot_ext_reg == expanded(mode_reg))
		else $error("bus pin ownership wrong for mode");
	a_reset_inputs: assert property (cap_state != CAP_RUN |=> pin_oe == '0)
		else $error("pin driven before mode known");
	a_periph_route: assert property (cap_state == CAP_RUN |=>
		((pin_out ^ $past(periph_out)) & $past(psel_reg & ~own_reg)) == '0
		&& ((pin_oe ^ $past(periph_oe)) & $past(psel_reg & ~own_reg)) == '0)
		else $error("peripheral pin not routed");
	a_gpio_route: assert property (cap_state == CAP_RUN |=>
		((pin_out ^ $past(data_reg)) & $past(~psel_reg & ~own_reg)) == '0
		&& ((pin_oe ^ $past(dir_reg)) & $past(~psel_reg & ~own_reg)) == '0)
		else $error("gpio pin not following data and direction");
	a_event_sticky: assert property (rise_arr != '0 |=>
		(istat_reg & $past(rise_arr)) == $past(rise_arr))
		else $error("pin event lost");
	a_read_clears: assert property (s_istat_read ##1 rvalid_reg |->
		(istat_reg & $past(rd_clr) & ~$past(rise_arr)) == '0)
		else $error("status not cleared by read");
	a_pin_isolate: assert property (wr_pin_mask != '0 |=>
		((data_reg ^ $past(data_reg)) & ~$past(wr_pin_mask)) == '0)
		else $error("per-pin write touched another pin");
	a_irq_masked: assert property (((istat_reg & imask_reg) == '0) && rise_arr == '0 |=> !irq)
		else $error("interrupt without unmasked flag");
	a_write_answer: assert property (s_axi_awvalid && awready_reg && s_axi_wvalid && wready_reg
		|-> ##2 bvalid_reg)
		else $error("write response late");
	a_read_hold: assert property (rvalid_reg && !s_axi_rready |=> rvalid_reg && $stable(rdata_reg))
		else $error("read data not held");
	a_swap_map: assert property (swap_reg && rd_take && s_axi_araddr[11:8] == SLOT_PRI
		|-> rd_slot == SLOT_ALT)
		else $error("swap not applied");

endmodule // pinu_top

// [core/pinu_pkg.sv]
// pinu_pkg: shared constants and types of the pin integration unit
package pinu_pkg;

	// geometry
	localparam int NPORT_MAX = 9;
	localparam int PWIDTH    = 16;

	// register offsets inside one port slot (slot = address bits 11:8)
	localparam logic [7:0] OFS_DATA     = 8'h00;
	localparam logic [7:0] OFS_DIR      = 8'h04;
	localparam logic [7:0] OFS_PSEL     = 8'h08;
	localparam logic [7:0] OFS_IMASK    = 8'h0c;
	localparam logic [7:0] OFS_FEN      = 8'h10;
	localparam logic [7:0] OFS_LEVEL    = 8'h14;
	localparam logic [7:0] OFS_ISTAT    = 8'h18;
	localparam logic [7:0] OFS_PIN_BASE = 8'h40;
	localparam logic [7:0] OFS_MIRROR   = 8'h80;

	// global slot and its registers
	localparam logic [3:0] SLOT_GLB     = 4'h9;
	localparam logic [7:0] OFS_GCTRL    = 8'h00;
	localparam logic [7:0] OFS_GSTAT    = 8'h04;

	// slots exchanged by the swap bit
	localparam logic [3:0] SLOT_PRI     = 4'h2;
	localparam logic [3:0] SLOT_ALT     = 4'h7;

	// per-pin and global control register fields
	localparam int PINB_DATA  = 0;
	localparam int PINB_DIR   = 1;
	localparam int PINB_PSEL  = 2;
	localparam int PINB_LEVEL = 3;
	localparam int GCTRL_SWAP = 0;

	// reset values
	localparam logic [PWIDTH-1:0] RST_DATA = 16'h0000;
	localparam logic [PWIDTH-1:0] RST_DIR  = 16'h0000;
	localparam logic [PWIDTH-1:0] RST_PSEL = 16'h0000;

	// timing
	localparam int CLK_PERIOD_NS = 4;
	localparam int FILT_TIME_NS  = 100;
	localparam int FILT_CYCLES   = (FILT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// bus answers
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// mode straps
	localparam logic [1:0] STRAP_SINGLE = 2'b00;
	localparam logic [1:0] STRAP_EXP    = 2'b01;
	localparam logic [1:0] STRAP_DFLASH = 2'b10;

	typedef enum logic [2:0] {
		MODE_NSC  = 3'b000,
		MODE_NEXP = 3'b001,
		MODE_SSC  = 3'b010,
		MODE_SEXP = 3'b011,
		MODE_DFB  = 3'b100,
		MODE_SDFB = 3'b101
	} pinu_mode_t;

	typedef enum logic [1:0] {
		CAP_SYNC0 = 2'b00,
		CAP_SYNC1 = 2'b01,
		CAP_TAKE  = 2'b10,
		CAP_RUN   = 2'b11
	} pinu_cap_t;

endpackage

// [core/pinu_filt_if.sv]
// pinu_filt_if: raw pin levels in, filtered levels and rising events out
`timescale 1ns/1ns
interface pinu_filt_if #(parameter int N = 16);
	logic [N-1:0] raw;
	logic [N-1:0] enable;
	logic [N-1:0] level;
	logic [N-1:0] rise;
	modport src (output raw, output enable, input level, input rise);
	modport flt (input raw, input enable, output level, output rise);
endinterface

// [core/pinu_filter.sv]
// pinu_filter: per-pin glitch filter and rising edge detector
`timescale 1ns/1ns
module pinu_filter
#(
	parameter int N   = 16,
	parameter int CYC = pinu_pkg::FILT_CYCLES
)
(
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// filter channel
	pinu_filt_if.flt  f
);
	import pinu_pkg::*;

	localparam int CW = $clog2(CYC + 1);
	localparam logic [CW-1:0] CNT_TOP = CW'(CYC);

	logic [N-1:0] level_reg;
	logic [N-1:0] level_d_reg;

	genvar i;
	generate
		for (i = 0; i < N; i++)
		begin : g_pin
			logic [CW-1:0] cnt_reg;
			logic          lvl_reg;
			// a changed level is accepted only after it held for the full window
			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					cnt_reg <= '0;
					lvl_reg <= 1'b0;
				end
				else if (!f.enable[i] || f.raw[i] == lvl_reg)
				begin
					cnt_reg <= '0;
					lvl_reg <= f.raw[i];
				end
				else if (cnt_reg == CNT_TOP - 1'b1)
				begin
					cnt_reg <= '0;
					lvl_reg <= f.raw[i];
				end
				else
					cnt_reg <= cnt_reg + 1'b1;
			end
			// each pin owns its own bit, so no two processes share a variable
			assign level_reg[i] = lvl_reg;
		end
	endgenerate

	// previous accepted level, reset low like the level itself
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			level_d_reg <= '0;
		else
			level_d_reg <= level_reg;
	end

	assign f.level = level_reg;
	// rising edge of the accepted level, one cycle wide
	assign f.rise  = level_reg & ~level_d_reg;

endmodule // pinu_filter

// [tb/pinu_partner.sv]
// pinu_partner: package pads as seen from the board side of the unit
`timescale 1ns/1ns
module pinu_partner
#(
	parameter int N = 144
)
(
	// unit pad drivers
	input  wire logic [N-1:0] pin_out,
	input  wire logic [N-1:0] pin_oe,
	// board level where the unit lets go
	input  wire logic [N-1:0] ext_lvl,
	// level seen at the pad input
	output logic      [N-1:0] pin_in
);
	// pad level resolution
	// a driven pad shows the unit value, an undriven one the board level
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule // pinu_partner

// [tb/pin_port_integration_tb.sv]
// pin_port_integration_tb: self-checking bench of the pin integration unit
`timescale 1ns/1ns
`define CHK(nm, e, g) chk(nm, 144'(e), 144'(g))
module pin_port_integration_tb;
	import pinu_pkg::*;
	// bus, pads and status
	logic             clk, rst_n, boot_ext, irq, flash_secure, eb;
	logic [11:0]      s_axi_awaddr, s_axi_araddr;
	logic             s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic             s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic             s_axi_rvalid, s_axi_rready;
	logic [31:0]      s_axi_wdata, s_axi_rdata, rdv;
	logic [3:0]       s_axi_wstrb;
	logic [1:0]       s_axi_bresp, s_axi_rresp, mode_strap, rsp;
	logic [8:0][15:0] pin_in, pin_out, pin_oe, periph_out, periph_oe, periph_in;
	logic [8:0][15:0] ext_out, ext_oe, ext_own, ext_lvl;
	logic [15:0]      dv [9];
	logic [15:0]      dirv [9];
	logic [15:0]      sv;
	pinu_mode_t       chip_mode, m;
	int               err_count, checks_done, k;

	pinu_top dut (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out, .pin_oe, .periph_out, .periph_oe,
		.periph_in, .ext_out, .ext_oe, .ext_own, .boot_ext, .mode_strap, .flash_secure,
		.chip_mode, .irq);
	pinu_partner pads (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl), .pin_in(pin_in));

	// 250 mhz clock
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [143:0] e, input logic [143:0] g);
		checks_done++;
		if (g !== e)
		begin
			err_count++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask

	function automatic logic [11:0] ad(input int p, input logic [7:0] o);
		return {4'(p), o};
	endfunction

	// expected synced level of a gpio port
	function automatic logic [15:0] lvl(input int p);
		return (dirv[p] & dv[p]) | (~dirv[p] & ext_lvl[p]);
	endfunction

	function automatic pinu_mode_t mexp(input logic [1:0] st, input logic sec);
		if (st == STRAP_EXP)
			return sec ? MODE_SEXP : MODE_NEXP;
		if (st == STRAP_DFLASH)
			return sec ? MODE_SDFB : MODE_DFB;
		return sec ? MODE_SSC : MODE_NSC;
	endfunction

	// write: address and data offered together, each dropped once taken
	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= {16'h0000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		forever
		begin
			@(posedge clk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid)
			begin
				rsp = s_axi_bresp;
				break;
			end
		end
	endtask

	task automatic rd(input logic [11:0] a);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		forever
		begin
			@(posedge clk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid)
			begin
				rdv = s_axi_rdata;
				rsp = s_axi_rresp;
				break;
			end
		end
	endtask

	task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
		rd(a);
		`CHK(nm, e, rdv);
		`CHK("rresp", RESP_OKAY, rsp);
	endtask

	// straps held steady across reset release
	task automatic do_reset(input logic [1:0] st, input logic sec);
		rst_n        <= 1'b0;
		mode_strap   <= st;
		flash_secure <= sec;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (6) @(posedge clk);
	endtask

	task automatic close_out;
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// hang guard, far beyond the expected run
	initial
	begin
		repeat (20000) @(posedge clk);
		err_count++;
		close_out;
	end

	// main sequence
	initial
	begin
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
		{s_axi_arvalid, mode_strap, flash_secure} = '0;
		// answers are always accepted, so back-to-back calls never toggle a ready
		{s_axi_bready, s_axi_rready} = 2'b11;
		s_axi_wstrb = 4'h3;
		rst_n = 1'b0;
		err_count = 0;
		checks_done = 0;
		void'($urandom(99859));
		for (int p = 0; p < 9; p++)
			{ext_lvl[p], periph_out[p], periph_oe[p], ext_out[p], ext_oe[p]} = 80'({$urandom,
				$urandom, $urandom});
		do_reset(STRAP_SINGLE, 1'b0);
		`CHK("oe_rst", 0, pin_oe);
		`CHK("own_rst", 0, ext_own);
		// port-wide access on all nine ports
		for (int p = 0; p < 9; p++)
		begin
			dv[p] = 16'($urandom);
			dirv[p] = 16'($urandom);
			wr(ad(p, OFS_DATA), dv[p]);
			wr(ad(p, OFS_DIR), dirv[p]);
			repeat (5) @(posedge clk);
			`CHK("pin_out", dv[p], pin_out[p]);
			`CHK("pin_oe", dirv[p], pin_oe[p]);
			rchk("data_rb", ad(p, OFS_DATA), dv[p]);
			rchk("level", ad(p, OFS_LEVEL), lvl(p));
		end
		// a pin register reaches one pin only
		k = $urandom_range(15);
		wr(ad(4, OFS_PIN_BASE + 8'(4 * k)), 16'h0003);
		dv[4][k] = 1'b1;
		dirv[4][k] = 1'b1;
		repeat (5) @(posedge clk);
		`CHK("pin_bit", {dv[5], dv[4], dv[3], dirv[4]}, {pin_out[5:3], pin_oe[4]});
		sv = lvl(4);
		rchk("pin_reg", ad(4, OFS_PIN_BASE + 8'(4 * k)), {28'h0, sv[k], 3'b011});
		// mirror writes data, reads level and data
		dv[5] = 16'($urandom);
		wr(ad(5, OFS_MIRROR), dv[5]);
		repeat (5) @(posedge clk);
		rchk("mirror", ad(5, OFS_MIRROR), {lvl(5), dv[5]});
		sv = 16'($urandom);
		wr(ad(6, OFS_PSEL), sv);
		repeat (3) @(posedge clk);
		`CHK("psel_out", (sv & periph_out[6]) | (~sv & dv[6]), pin_out[6]);
		`CHK("psel_oe", (sv & periph_oe[6]) | (~sv & dirv[6]), pin_oe[6]);
		`CHK("psel_other", dv[8], pin_out[8]);
		// unmapped places answer with an error
		wr(ad(0, 8'h20), 16'h1234);
		`CHK("unmap_w", RESP_SLVERR, rsp);
		rd(12'ha00);
		`CHK("unmap_r", RESP_SLVERR, rsp);
		// slot exchange for reads and writes
		wr(12'h900, 16'h0001);
		rchk("swap_rd", ad(7, OFS_DATA), dv[2]);
		wr(ad(2, OFS_DATA), 16'ha5c3);
		dv[7] = 16'ha5c3;
		repeat (3) @(posedge clk);
		`CHK("swap_pin", dv[7], pin_out[7]);
		wr(12'h900, 16'h0000);
		rchk("swap_off", ad(7, OFS_DATA), dv[7]);
		// masked and unmasked events, read clear, noise filter
		wr(ad(0, OFS_DIR), 16'h0000);
		wr(ad(0, OFS_IMASK), 16'h0001);
		ext_lvl[0] <= 16'h0000;
		repeat (8) @(posedge clk);
		rd(ad(0, OFS_ISTAT));
		ext_lvl[0] <= 16'h0002;
		repeat (10) @(posedge clk);
		`CHK("irq_masked", 1'b0, irq);
		ext_lvl[0] <= 16'h0003;
		for (k = 0; k < 20 && irq !== 1'b1; k++) @(posedge clk);
		`CHK("irq_set", 1'b1, irq);
		rchk("istat", ad(0, OFS_ISTAT), 32'h3);
		repeat (3) @(posedge clk);
		`CHK("irq_clr", 1'b0, irq);
		wr(ad(0, OFS_FEN), 16'h0004);
		ext_lvl[0] <= 16'h0007;
		repeat (FILT_CYCLES / 2) @(posedge clk);
		ext_lvl[0] <= 16'h0003;
		repeat (FILT_CYCLES + 15) @(posedge clk);
		rchk("filt_glitch", ad(0, OFS_ISTAT), 32'h0);
		ext_lvl[0] <= 16'h0007;
		repeat (FILT_CYCLES + 15) @(posedge clk);
		rchk("filt_pass", ad(0, OFS_ISTAT), 32'h4);
		for (int i = 0; i < 8; i++)
		begin
			do_reset(2'(i), i[2]);
			m = mexp(2'(i), i[2]);
			eb = (m == MODE_NEXP) || (m == MODE_SEXP);
			`CHK("mode", m, chip_mode);
			`CHK("boot", eb, boot_ext);
			rchk("gstat", 12'h904, {28'h0, eb, m});
		end
		// bus pins stay with the bus unit whatever software writes
		do_reset(STRAP_EXP, 1'b0);
		wr(ad(0, OFS_PSEL), 16'hffff);
		wr(ad(1, OFS_DIR), 16'hffff);
		repeat (3) @(posedge clk);
		`CHK("own", {112'h0, 32'hffff_ffff}, ext_own);
		`CHK("own_out", ext_out[1:0], pin_out[1:0]);
		`CHK("own_oe", ext_oe[1:0], pin_oe[1:0]);
		close_out;
	end
endmodule // pin_port_integration_tb
